// ===== fdm_ctrl.sv
// Flash data memory sequencer with Avalon-MM register slave
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "fdm_regs.svh"

module fdm_ctrl #(
  parameter int READ_CYC = `FDM_READ_CYC,
  parameter int PROG_CYC = `FDM_PROG_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             avs_response_err,
  output logic             busy,
  input  wire logic        code_protect
);

  // Byte address to word index
  logic [3:0] idx;
  assign idx = avs_address[5:2];

  // Software-visible registers
  logic [5:0]  addr_q, addr_d;
  logic [7:0]  data_q, data_d;

  // Unlock sequence: pending bits and their one-access windows
  logic        rowclr_q, rowclr_d;
  logic        unlock_q, unlock_d;
  logic        rowclr_age_q, rowclr_age_d;
  logic        unlock_age_q, unlock_age_d;

  // Sequencer state and bus answer registers
  logic        busy_q, busy_d;
  logic        wait_q, wait_d;
  logic        waitreq_q, waitreq_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  fdm_pkg::fdm_state_e   st_q, st_d;

  // Array and timer hookup
  fdm_pkg::fdm_arr_req_s arr_req;
  logic [7:0]  arr_rdata;
  logic        tmr_load;
  logic [7:0]  tmr_count;
  logic        tmr_done;
  logic        cpu_unused;

  // Protection strap does not gate the core's own access
  // It only limits readout from outside, which this block does not model
  assign cpu_unused = code_protect;

  // Array reachable only through this sequencer
  fdm_array #(
    .ROWS      (8),
    .ROW_BYTES (8)
  ) u_array (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .req     (arr_req),
    .rdata   (arr_rdata)
  );

  // One timer serves every busy phase; phases never overlap
  fdm_cycle_timer #(
    .W (8)
  ) u_timer (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .load    (tmr_load),
    .count   (tmr_count),
    .done    (tmr_done)
  );

  // One access per bus cycle; the cycle after a request is taken is its answer phase
  // A request is taken only outside the answer cycle and outside a stall;
  // byte lane 0 must be enabled for a write to count
  logic acc;
  logic wr_acc;
  logic bset;
  logic [7:0] wb;
  assign acc    = (avs_read || avs_write) && !wait_q && !busy_q;
  assign wr_acc = acc && avs_write && avs_byteenable[0];
  assign bset   = wr_acc && (idx == `FDM_OFS_BSET);
  assign wb     = avs_writedata[7:0];

  // A pending enable dies on the first accepted access after its set unless that access is its follow-up bit-set.
  // Counting accesses rather than clocks keeps the window tied to instruction
  // cycles even when the core idles between accesses.
  function automatic logic pending_kept(input logic aged, input logic follow_up,
                                        input logic taken);
    logic dies;
    dies         = aged && taken && !follow_up;
    pending_kept = !dies;
  endfunction : pending_kept

  // Sequencer, registers and bus answer
  always_comb
  begin
    // Hold by default; answer flags are one-cycle pulses
    addr_d       = addr_q;
    data_d       = data_q;
    rowclr_d     = rowclr_q;
    unlock_d     = unlock_q;
    rowclr_age_d = 1'b0;
    unlock_age_d = 1'b0;
    st_d         = st_q;
    busy_d       = busy_q;
    wait_d       = 1'b0;
    rdata_d      = rdata_q;
    err_d        = 1'b0;
    arr_req      = '{wr_en: 1'b0, row_en: 1'b0, addr: addr_q, wdata: data_q};
    tmr_load     = 1'b0;
    tmr_count    = 8'h00;

    // Enable bits die after one access window unless that access is their follow-up; a fresh set
    // further down overrides this clear, so set wins over timeout
    if (!pending_kept(rowclr_age_q, bset && wb[`FDM_BIT_UNLOCK], acc))
      rowclr_d = 1'b0;
    if (!pending_kept(unlock_age_q, bset && wb[`FDM_BIT_WR], acc))
      unlock_d = 1'b0;
    // Window closes at the next accepted access, whatever it is
    rowclr_age_d = rowclr_age_q && !acc;
    unlock_age_d = unlock_age_q && !acc;

    unique case (st_q)
      fdm_pkg::FDM_IDLE:
      begin
        if (acc)
        begin
          wait_d = 1'b1;
          // Writes act at the take edge; the answer follows one cycle later
          if (avs_write)
          begin
            if (wr_acc)
            begin
              unique case (idx)
                // Only the low six bits address the array
                `FDM_OFS_ADDR: addr_d = wb[5:0];
                `FDM_OFS_DATA: data_d = wb;
                `FDM_OFS_CTRL:
                begin
                  // Plain write may only set row-clear; unlock and trigger bits are ignored
                  // A repeat set restarts the window, so set wins over timeout
                  if (wb[`FDM_BIT_ROWCLR])
                  begin
                    rowclr_d     = 1'b1;
                    rowclr_age_d = 1'b1;
                  end
                end
                `FDM_OFS_BSET:
                begin
                  // One bit acted on per bit-set, read first
                  if (wb[`FDM_BIT_RD])
                  begin
                    st_d      = fdm_pkg::FDM_READ;
                    busy_d    = 1'b1;
                    tmr_load  = 1'b1;
                    tmr_count = 8'(READ_CYC);
                  end
                  else if (wb[`FDM_BIT_ROWCLR])
                  begin
                    rowclr_d     = 1'b1;
                    rowclr_age_d = 1'b1;
                  end
                  else if (wb[`FDM_BIT_UNLOCK])
                  begin
                    // Only this path sets unlock; plain writes cannot
                    unlock_d     = 1'b1;
                    unlock_age_d = 1'b1;
                  end
                  // Trigger without a live unlock falls through and starts nothing
                  else if (wb[`FDM_BIT_WR] && unlock_q && unlock_age_q)
                  begin
                    // Pending row-clear picks erase over program
                    st_d      = rowclr_q ? fdm_pkg::FDM_ERASE : fdm_pkg::FDM_PROG;
                    busy_d    = 1'b1;
                    tmr_load  = 1'b1;
                    tmr_count = 8'(PROG_CYC);
                  end
                end
                `FDM_OFS_STAT: err_d = 1'b0;
                default:       err_d = 1'b1;
              endcase
            end
          end
          else
          begin
            unique case (idx)
              `FDM_OFS_ADDR: rdata_d = {26'h0, addr_q};
              `FDM_OFS_DATA: rdata_d = {24'h0, data_q};
              // Control reads back the live enable bits
              `FDM_OFS_CTRL: rdata_d = {28'h0, rowclr_q, unlock_q, 2'b00};
              `FDM_OFS_STAT: rdata_d = {31'h0, busy_q};
              `FDM_OFS_BSET: rdata_d = 32'h0;
              default:
              begin
                // Unmapped reads give zero with the error pulse
                rdata_d = 32'h0;
                err_d   = 1'b1;
              end
            endcase
          end
        end
      end
      // Byte lands as the stall ends, so the next access already sees it
      fdm_pkg::FDM_READ:
      begin
        if (tmr_done)
        begin
          data_d = arr_rdata;
          st_d   = fdm_pkg::FDM_IDLE;
          busy_d = 1'b0;
        end
      end
      // Array changes only on the last busy cycle; enables drop with it
      fdm_pkg::FDM_ERASE, fdm_pkg::FDM_PROG:
      begin
        if (tmr_done)
        begin
          arr_req.row_en = (st_q == fdm_pkg::FDM_ERASE);
          arr_req.wr_en  = (st_q == fdm_pkg::FDM_PROG);
          rowclr_d = 1'b0;
          unlock_d = 1'b0;
          st_d     = fdm_pkg::FDM_IDLE;
          busy_d   = 1'b0;
        end
      end
    endcase

    // Registered waitrequest so the bus output comes straight from a flop
    waitreq_d = !wait_d;
  end

  // State registers; waitrequest resets high so no answer shows in reset
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_q       <= `FDM_ADDR_RST;
      data_q       <= `FDM_DATA_RST;
      rowclr_q     <= 1'b0;
      unlock_q     <= 1'b0;
      rowclr_age_q <= 1'b0;
      unlock_age_q <= 1'b0;
      st_q         <= fdm_pkg::FDM_IDLE;
      busy_q       <= 1'b0;
      wait_q       <= 1'b0;
      waitreq_q    <= 1'b1;
      rdata_q      <= 32'h0;
      err_q        <= 1'b0;
    end
    else
    begin
      addr_q       <= addr_d;
      data_q       <= data_d;
      rowclr_q     <= rowclr_d;
      unlock_q     <= unlock_d;
      rowclr_age_q <= rowclr_age_d;
      unlock_age_q <= unlock_age_d;
      st_q         <= st_d;
      busy_q       <= busy_d;
      wait_q       <= wait_d;
      waitreq_q    <= waitreq_d;
      rdata_q      <= rdata_d;
      err_q        <= err_d;
    end
  end

  // Waitrequest low only in the answer cycle, so a stall just holds the master
  // A stalled request costs wait states only; it is never dropped
  assign avs_waitrequest  = waitreq_q;
  assign avs_readdata     = rdata_q;
  assign avs_response_err = err_q;
  assign busy             = busy_q;

endmodule : fdm_ctrl

// ===== fdm_regs.svh
// Register offsets, control bit positions and timing constants of the flash data block
`ifndef FDM_REGS_SVH
`define FDM_REGS_SVH

// Avalon word offsets (byte address = 4 * index)
`define FDM_OFS_ADDR      4'h0
`define FDM_OFS_DATA      4'h1
`define FDM_OFS_CTRL      4'h2
`define FDM_OFS_STAT      4'h3
`define FDM_OFS_BSET      4'h4

// Control register bit positions
`define FDM_BIT_RD        3'h0
`define FDM_BIT_WR        3'h1
`define FDM_BIT_UNLOCK    3'h2
`define FDM_BIT_ROWCLR    3'h3

// Array geometry and reset values
`define FDM_ROW_MSB       5
`define FDM_ROW_LSB       3
`define FDM_ERASED        8'hFF
`define FDM_ADDR_RST      6'h00
`define FDM_DATA_RST      8'h00

// Busy times in ns and derived cycle counts at 8 ns per cycle
`define FDM_CLK_NS        8
`define FDM_READ_NS       16
`define FDM_PROG_NS       400
`define FDM_READ_CYC      ((`FDM_READ_NS + `FDM_CLK_NS - 1) / `FDM_CLK_NS)
`define FDM_PROG_CYC      ((`FDM_PROG_NS + `FDM_CLK_NS - 1) / `FDM_CLK_NS)

`endif

// ===== fdm_pkg.sv
// Types shared by the flash data block
package fdm_pkg;

  typedef enum logic [3:0] {
    FDM_IDLE  = 4'b0001,
    FDM_READ  = 4'b0010,
    FDM_ERASE = 4'b0100,
    FDM_PROG  = 4'b1000
  } fdm_state_e;

  // One array access request from the sequencer
  typedef struct packed {
    logic       wr_en;
    logic       row_en;
    logic [5:0] addr;
    logic [7:0] wdata;
  } fdm_arr_req_s;

endpackage : fdm_pkg

// ===== fdm_array.sv
// Flop-based 64-byte data array, row erase and byte program
`timescale 1ns/1ps
`include "fdm_regs.svh"

module fdm_array #(
  parameter int ROWS = 8,
  parameter int ROW_BYTES = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire fdm_pkg::fdm_arr_req_s req,
  output logic [7:0]            rdata
);

  localparam int DEPTH = ROWS * ROW_BYTES;

  logic [7:0] mem_q [DEPTH];
  logic [7:0] mem_d [DEPTH];

  // Erase sets whole row to erased level; program writes one byte
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_d[i] = mem_q[i];
      if (req.row_en && (i / ROW_BYTES) == int'(req.addr[`FDM_ROW_MSB:`FDM_ROW_LSB]))
        mem_d[i] = `FDM_ERASED;
      else if (req.wr_en && i == int'(req.addr))
        mem_d[i] = req.wdata;
    end
  end

  // Reset to erased; real flash would retain, kept simple here
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= `FDM_ERASED;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= mem_d[i];
    end
  end

  assign rdata = mem_q[req.addr];

endmodule : fdm_array

// ===== fdm_cycle_timer.sv
// Down counter that times busy phases of the sequencer
`timescale 1ns/1ps

module fdm_cycle_timer #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Load wins; done flags the last cycle of the count
  always_comb
  begin
    if (load)
      cnt_d = count;
    else if (cnt_q != '0)
      cnt_d = cnt_q - W'(1);
    else
      cnt_d = cnt_q;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign done = (cnt_q == W'(1)) && !load;

endmodule : fdm_cycle_timer

// ===== fdm_ctrl_monitor.sv
// Bus answer, stall and error checks for the flash data sequencer
`timescale 1ns/1ps
module fdm_ctrl_monitor #(
  parameter int READ_CYC = 2,
  parameter int PROG_CYC = 50
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        avs_response_err,
  input wire logic        busy,
  input wire logic        code_protect
);
  logic [7:0] blen_q;
  logic [7:0] blen_d;
  logic       req;
  logic       ans;
  // Busy length counter, so stall time is compared exactly
  always_comb blen_d = busy ? blen_q + 8'h01 : 8'h00;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      blen_q <= 8'h00;
    else
      blen_q <= blen_d;
  // Request and answer qualifiers
  assign req = avs_read | avs_write;
  assign ans = req & !avs_waitrequest;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_idle_wait;
    !req |-> avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("answer without request");
  property p_one_ans;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one_ans: assert property (p_one_ans) else $error("answer longer than a cycle");
  property p_fresh_ans;
    $rose(req) && !busy |=> !avs_waitrequest;
  endproperty
  a_fresh_ans: assert property (p_fresh_ans) else $error("idle answer late");
  property p_stall_bound;
    $rose(req) |-> ##[1:80] !avs_waitrequest;
  endproperty
  a_stall_bound: assert property (p_stall_bound) else $error("stall never ends");
  property p_busy_len;
    $fell(busy) |-> (blen_q == READ_CYC || blen_q == PROG_CYC);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_err_unm;
    ans && avs_address[5:2] > 4'h4 |-> avs_response_err;
  endproperty
  a_err_unm: assert property (p_err_unm) else $error("unmapped access not flagged");
  property p_err_map;
    avs_response_err |-> ans && avs_address[5:2] > 4'h4;
  endproperty
  a_err_map: assert property (p_err_map) else $error("error on mapped access");
  property p_bset_zero;
    ans && avs_read && avs_address[5:2] == 4'h4 |-> avs_readdata == 32'h0;
  endproperty
  a_bset_zero: assert property (p_bset_zero) else $error("bit-set port reads nonzero");
  c_busy: cover property ($rose(busy));
  c_err: cover property (avs_response_err);
  c_long: cover property ($fell(busy) && blen_q == PROG_CYC);
endmodule : fdm_ctrl_monitor

bind fdm_ctrl fdm_ctrl_monitor #(.READ_CYC(READ_CYC), .PROG_CYC(PROG_CYC)) u_mon (
  .clk_sys, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .avs_response_err, .busy, .code_protect);

// ===== fdm_core_model.sv
// Processor core model: one register access per instruction
`timescale 1ns/1ps
module fdm_core_model (
  input  wire logic        clk_sys,
  output logic [5:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic        avs_response_err,
  output logic             to_out
);
  // Idle bus at time zero
  initial
  begin
    avs_address    = 6'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hF;
    to_out         = 1'b0;
  end
  // Request held until waitrequest is seen low; bit-set writes carry one bit
  task automatic acc(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
                     input logic [3:0] be, output logic [7:0] rd,
                     output logic err);
    int n;
    @(posedge clk_sys);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    for (n = 0; n < 200 && avs_waitrequest !== 1'b0; n++)
      @(posedge clk_sys);
    if (n >= 200)
      to_out = 1'b1;
    rd = avs_readdata[7:0];
    err = avs_response_err;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_byteenable <= 4'hF;
    avs_writedata <= ~avs_writedata; // Released data must not look valid
  endtask : acc
endmodule : fdm_core_model

// ===== test_flash_data_memory_control.sv
// Self-checking bench for the flash data sequencer
`timescale 1ns/1ps
module test_flash_data_memory_control;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        code_protect = 1'b0;
  logic [5:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, avs_response_err, busy, to_out;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [7:0]  rd_v;
  logic        err_v;
  int          errors = 0;
  int          samples_checked = 0;
  always #4 clk_sys = ~clk_sys;
  // Short program time keeps the run brief
  fdm_ctrl #(.READ_CYC(2), .PROG_CYC(8)) u_dut (.clk_sys, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .avs_response_err, .busy, .code_protect);
  fdm_core_model u_core (.clk_sys, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err, .to_out);
  task automatic results;
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic acc(input logic wr, input logic [3:0] idx, input logic [7:0] d,
                     input logic [3:0] be = 4'hF);
    u_core.acc(wr, idx, d, be, rd_v, err_v);
    if (to_out === 1'b1)
    begin
      errors++;
      $display("MISMATCH timeout exp 0 got 1");
      results();
    end
  endtask : acc
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // Read one array byte; the data read follows the trigger with no filler
  task automatic rdb(input logic [5:0] a, input logic [7:0] exp);
    acc(1'b1, 4'h0, {2'b00, a});
    acc(1'b1, 4'h4, 8'h01);
    acc(1'b0, 4'h1, 8'h00);
    chk("array", exp, rd_v);
  endtask : rdb
  // Address, data, then unlock and trigger in consecutive instructions
  task automatic prog(input logic [5:0] a, input logic [7:0] d);
    acc(1'b1, 4'h0, {2'b00, a});
    acc(1'b1, 4'h1, d);
    acc(1'b1, 4'h4, 8'h04);
    acc(1'b1, 4'h4, 8'h02);
  endtask : prog
  initial
  begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    acc(1'b0, 4'h1, 8'h00);
    chk("data_rst", 8'h00, rd_v);
    rdb(6'h05, 8'hFF);
    acc(1'b0, 4'h3, 8'h00);
    chk("stat_rd", 8'h00, rd_v);
    acc(1'b0, 4'h1, 8'h00);
    chk("data_hold", 8'hFF, rd_v);
    code_protect <= 1'b1;
    prog(6'h0B, 8'h5A);
    rdb(6'h0B, 8'h5A);
    prog(6'h00, 8'h11);
    rdb(6'h00, 8'h11);
    acc(1'b1, 4'h1, 8'h00);
    acc(1'b1, 4'h4, 8'h02);
    rdb(6'h0B, 8'h5A);
    acc(1'b1, 4'h1, 8'h00);
    acc(1'b1, 4'h4, 8'h04);
    acc(1'b0, 4'h3, 8'h00);
    acc(1'b0, 4'h2, 8'h00);
    chk("unlock_clr", 8'h00, rd_v & 8'h04);
    acc(1'b1, 4'h4, 8'h02);
    rdb(6'h0B, 8'h5A);
    acc(1'b1, 4'h4, 8'h08);
    acc(1'b0, 4'h3, 8'h00);
    acc(1'b0, 4'h2, 8'h00);
    chk("rowclr_clr", 8'h00, rd_v & 8'h08);
    // Row 1 erase started by a plain control write
    acc(1'b1, 4'h0, 8'h0F);
    acc(1'b1, 4'h2, 8'h08);
    acc(1'b1, 4'h4, 8'h04);
    acc(1'b1, 4'h4, 8'h02);
    rdb(6'h0B, 8'hFF);
    rdb(6'h00, 8'h11);
    // Row 0 erase through bit-set instructions only
    acc(1'b1, 4'h0, 8'h02);
    acc(1'b1, 4'h4, 8'h08);
    acc(1'b1, 4'h4, 8'h04);
    acc(1'b1, 4'h4, 8'h02);
    rdb(6'h00, 8'hFF);
    // Plain control writes neither read nor unlock
    acc(1'b1, 4'h1, 8'h77);
    acc(1'b1, 4'h2, 8'h01);
    acc(1'b0, 4'h1, 8'h00);
    chk("plain_rd", 8'h77, rd_v);
    acc(1'b1, 4'h2, 8'h04);
    acc(1'b1, 4'h4, 8'h02);
    rdb(6'h00, 8'hFF);
    // Write with lane 0 off is ignored
    acc(1'b1, 4'h1, 8'hA5, 4'h0);
    acc(1'b0, 4'h1, 8'h00);
    chk("be_off", 8'hFF, rd_v);
    // Repeat row-clear set restarts its window
    acc(1'b1, 4'h2, 8'h08);
    acc(1'b1, 4'h2, 8'h08);
    acc(1'b0, 4'h2, 8'h00);
    chk("rowclr_reset", 8'h08, rd_v & 8'h08);
    // Program into the freshly erased row, then status after the stall
    prog(6'h02, 8'hC3);
    acc(1'b0, 4'h3, 8'h00);
    chk("stat_prog", 8'h00, rd_v);
    rdb(6'h02, 8'hC3);
    acc(1'b0, 4'h5, 8'h00);
    chk("unmapped_err", 8'h01, {7'h00, err_v});
    chk("unmapped_data", 8'h00, rd_v);
    results();
  end
endmodule : test_flash_data_memory_control
